// ---- src/kef_top.sv ----
// Event queue, device reset control and register access of the key event block
`timescale 1ns/10ps

module kef_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_rst_b,
	// Fill side
	input  wire logic                       i_in_valid,
	output logic                            o_in_ready,
	input  wire logic [WIDTH-1:0]           i_in_data,
	// Drain side
	output logic                            o_out_valid,
	input  wire logic                       i_out_ready,
	output logic [WIDTH-1:0]                o_out_data,
	// Occupancy
	output logic [$clog2(DEPTH+1)-1:0]      o_count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    rd_ptr;
	logic [AW-1:0]    wr_ptr;
	logic [CW-1:0]    count;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW-1:0]    next_wr_ptr;
	logic [CW-1:0]    next_count;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count != CW'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];
	assign o_count     = count;

	// Head always read from the read pointer; ring avoids moving data
	always_comb
	begin
		push        = i_in_valid && o_in_ready;
		pop         = i_out_ready && o_out_valid;
		next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
		next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
		next_count  = count;
		if (push && !pop)
		begin
			next_count = count + CW'(1);
		end
		else if (pop && !push)
		begin
			next_count = count - CW'(1);
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (push)
		begin
			mem[wr_ptr] <= i_in_data;
		end
	end
endmodule

module kef_top
	import kef_pkg::*;
(
	// Clock and chip reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_b,
	// External reset pin, asynchronous to i_clk
	input  wire logic                   i_rst_pin_b,
	// Register access from the serial slave
	input  wire logic [7:0]             i_reg_addr,
	input  wire logic                   i_reg_rd,
	input  wire logic                   i_reg_wr,
	input  wire logic [7:0]             i_reg_wdata,
	input  wire logic                   i_xfer_busy,
	output logic [7:0]                  o_reg_rdata,
	// Event sources
	input  wire logic                   i_evt_valid,
	input  wire kef_evt_req_t           i_evt_req,
	output logic                        o_evt_ready,
	// Interrupt pin, open drain
	output logic                        o_int_out,
	output logic                        o_int_oe,
	// Device state
	output logic                        o_in_reset
);
	// Pin synchroniser and debounce
	logic       pin_meta;
	logic       pin_sync;
	logic       pin_low;
	logic [7:0] deb_cnt;
	logic       next_pin_low;
	logic [7:0] next_deb_cnt;

	always_comb
	begin
		next_deb_cnt = deb_cnt;
		next_pin_low = pin_low;
		if (pin_sync == !pin_low)
		begin
			next_deb_cnt = '0;
		end
		else if (deb_cnt == DEBOUNCE_LAST)
		begin
			next_pin_low = !pin_sync;
			next_deb_cnt = '0;
		end
		else
		begin
			next_deb_cnt = deb_cnt + 8'h01;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_low  <= 1'b0;
			deb_cnt  <= '0;
		end
		else
		begin
			pin_meta <= i_rst_pin_b;
			pin_sync <= pin_meta;
			pin_low  <= next_pin_low;
			deb_cnt  <= next_deb_cnt;
		end
	end

	// Internal reset: chip reset, filtered pin, or one-cycle soft restart
	logic soft_restart;
	logic next_soft_restart;
	logic core_rst_b;

	// Soft restart is registered so it resets itself one cycle later
	always_comb
	begin
		next_soft_restart = i_reg_wr && (i_reg_addr == ADDR_RESTART)
			&& i_reg_wdata[RESTART_BIT] && !soft_restart;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			soft_restart <= 1'b0;
		end
		else
		begin
			soft_restart <= next_soft_restart;
		end
	end

	assign core_rst_b = i_rst_b && !pin_low && !soft_restart;

	// Queue
	logic     fifo_in_valid;
	logic     fifo_in_ready;
	logic     fifo_out_valid;
	logic     fifo_pop;
	kef_evt_t fifo_head;
	logic [TALLY_WIDTH-1:0] fifo_count;

	kef_fifo
	#(
		.WIDTH (ELEM_WIDTH),
		.DEPTH (QUEUE_DEPTH)
	)
	u_queue
	(
		.i_clk       (i_clk),
		.i_rst_b     (core_rst_b),
		.i_in_valid  (fifo_in_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (i_evt_req.evt),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_head),
		.o_count     (fifo_count)
	);

	// Control state
	logic [7:0] src_cfg;
	logic       stat_event;
	logic       stat_overrun;
	logic       queue_hold;
	logic [7:0] rdata;
	logic       evt_ready;
	logic       int_drive;
	logic [7:0] next_src_cfg;
	logic       next_stat_event;
	logic       next_stat_overrun;
	logic       next_queue_hold;
	logic [7:0] next_rdata;
	logic       next_evt_ready;
	logic       next_int_drive;
	logic       queue_addr;
	logic       src_allowed;
	logic       evt_take;

	always_comb
	begin
		queue_addr = (i_reg_addr >= ADDR_QUEUE_LO) && (i_reg_addr <= ADDR_QUEUE_HI);
		unique case (i_evt_req.src)
			KEF_SRC_KEY:   src_allowed = 1'b1;
			KEF_SRC_GPI:   src_allowed = src_cfg[CFG_GPI_BIT];
			KEF_SRC_LOGIC: src_allowed = src_cfg[CFG_LOGIC_BIT];
			default:       src_allowed = 1'b0;
		endcase
		// Held source waits; disabled source is taken and dropped
		evt_take      = i_evt_valid && evt_ready;
		fifo_in_valid = evt_take && src_allowed;
		fifo_pop      = i_reg_rd && queue_addr && fifo_out_valid;

		// Hold runs from the first queue access to the end of the transaction, not just the read cycle
		next_queue_hold = queue_hold;
		if (!i_xfer_busy)
		begin
			next_queue_hold = 1'b0;
		end
		else if ((i_reg_rd || i_reg_wr) && queue_addr)
		begin
			next_queue_hold = 1'b1;
		end
		next_evt_ready = !next_queue_hold;

		next_src_cfg = src_cfg;
		if (i_reg_wr && (i_reg_addr == ADDR_SRC_CFG))
		begin
			next_src_cfg = i_reg_wdata;
		end

		// Status: write one clears, a new event in the same cycle wins
		next_stat_event   = stat_event;
		next_stat_overrun = stat_overrun;
		if (i_reg_wr && (i_reg_addr == ADDR_STATUS))
		begin
			if (i_reg_wdata[STAT_EVENT_BIT])
			begin
				next_stat_event = 1'b0;
			end
			if (i_reg_wdata[STAT_OVERRUN_BIT])
			begin
				next_stat_overrun = 1'b0;
			end
		end
		if (fifo_in_valid)
		begin
			next_stat_event = 1'b1;
		end
		if (fifo_in_valid && !fifo_in_ready)
		begin
			next_stat_overrun = 1'b1;
		end

		next_int_drive = (next_stat_event && next_src_cfg[CFG_EVT_IEN_BIT])
			|| (next_stat_overrun && next_src_cfg[CFG_OVR_IEN_BIT]);

		next_rdata = rdata;
		if (i_reg_rd)
		begin
			next_rdata = 8'h00;
			if (queue_addr)
			begin
				next_rdata = fifo_out_valid ? fifo_head : 8'h00;
			end
			else
			begin
				unique case (i_reg_addr)
					ADDR_STATUS:
					begin
						next_rdata[STAT_EVENT_BIT]   = stat_event;
						next_rdata[STAT_OVERRUN_BIT] = stat_overrun;
					end
					ADDR_TALLY:   next_rdata = {3'h0, fifo_count};
					ADDR_SRC_CFG: next_rdata = src_cfg;
					default:      next_rdata = 8'h00;
				endcase
			end
		end
	end

	// All settings return to defaults on any reset source
	always_ff @(posedge i_clk)
	begin
		if (!core_rst_b)
		begin
			src_cfg      <= SRC_CFG_RESET;
			stat_event   <= 1'b0;
			stat_overrun <= 1'b0;
			queue_hold   <= 1'b0;
			rdata        <= 8'h00;
			evt_ready    <= 1'b0;
			int_drive    <= 1'b0;
		end
		else
		begin
			src_cfg      <= next_src_cfg;
			stat_event   <= next_stat_event;
			stat_overrun <= next_stat_overrun;
			queue_hold   <= next_queue_hold;
			rdata        <= next_rdata;
			evt_ready    <= next_evt_ready;
			int_drive    <= next_int_drive;
		end
	end

	// Output flops
	logic in_reset;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			in_reset <= 1'b1;
		end
		else
		begin
			in_reset <= !core_rst_b;
		end
	end

	assign o_reg_rdata = rdata;
	assign o_evt_ready = evt_ready;
	assign o_int_oe    = int_drive;
	assign o_int_out   = 1'b0;
	assign o_in_reset  = in_reset;
endmodule

// ---- src/kef_pkg.sv ----
// Constants and types for the key event queue block
// Operation
// - With supply good and reset pin high, start in standby with default settings.
// - While reset pin is low, hold reset and restore all settings to defaults.
// - Reset pin passes a debounce filter so short glitches are ignored.
// - Writing one to bit 2 of 0x3D resets the device like the pin.
// - Queue stores up to sixteen events, visible at registers 0x03 to 0x12.
// - Key events always queued; input and logic events only when enabled.
// - Five-bit tally in 0x02 bits 4:0 reports events currently held.
// - Each element is eight bits: identifier in bits 6:0, state in bit 7.
// - Any queue register read returns the head element, never a deeper one.
// - Queue copies are consecutive so one burst read drains the whole queue.
// - Pending events and status changes are signalled on the interrupt pin.
// - All configuration happens through host register writes only.
// - While a transaction touches queue addresses, new queue updates wait.
// - More than sixteen events sets overrun flag 0x01 bit 2, interrupt if enabled.
// - Recording sets pending flag 0x01 bit 0 and counts up; reads count down.
package kef_pkg;

	localparam int          QUEUE_DEPTH   = 16;
	localparam int          ELEM_WIDTH    = 8;
	localparam int          TALLY_WIDTH   = 5;

	localparam logic [7:0]  ADDR_STATUS   = 8'h01;
	localparam logic [7:0]  ADDR_TALLY    = 8'h02;
	localparam logic [7:0]  ADDR_QUEUE_LO = 8'h03;
	localparam logic [7:0]  ADDR_QUEUE_HI = 8'h12;
	localparam logic [7:0]  ADDR_SRC_CFG  = 8'h40;
	localparam logic [7:0]  ADDR_RESTART  = 8'h3D;

	localparam int          STAT_EVENT_BIT   = 0;
	localparam int          STAT_OVERRUN_BIT = 2;
	localparam int          RESTART_BIT      = 2;
	localparam int          CFG_GPI_BIT      = 0;
	localparam int          CFG_LOGIC_BIT    = 1;
	localparam int          CFG_OVR_IEN_BIT  = 2;
	localparam int          CFG_EVT_IEN_BIT  = 3;
	localparam logic [7:0]  SRC_CFG_RESET    = 8'h08;

	localparam int          CLK_PERIOD_PS    = 5000;
	localparam int          DEBOUNCE_NS      = 1000;
	localparam int          DEBOUNCE_CYCLES  = (DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam logic [7:0]  DEBOUNCE_LAST    = 8'(DEBOUNCE_CYCLES - 1);

	typedef enum logic [1:0] {
		KEF_SRC_KEY   = 2'h0,
		KEF_SRC_GPI   = 2'h1,
		KEF_SRC_LOGIC = 2'h2
	} kef_src_t;

	typedef struct packed {
		logic       state;
		logic [6:0] ident;
	} kef_evt_t;

	typedef struct packed {
		kef_src_t src;
		kef_evt_t evt;
	} kef_evt_req_t;

endpackage

// ---- tb/kef_top_props.sv ----
// Port checker for the key event block
`timescale 1ns/10ps
module kef_top_props
	import kef_pkg::*;
(
	input wire logic         i_clk,
	input wire logic         i_rst_b,
	input wire logic         i_rst_pin_b,
	input wire logic [7:0]   i_reg_addr,
	input wire logic         i_reg_rd,
	input wire logic         i_reg_wr,
	input wire logic [7:0]   i_reg_wdata,
	input wire logic         i_xfer_busy,
	input wire logic [7:0]   o_reg_rdata,
	input wire logic         i_evt_valid,
	input wire kef_evt_req_t i_evt_req,
	input wire logic         o_evt_ready,
	input wire logic         o_int_out,
	input wire logic         o_int_oe,
	input wire logic         o_in_reset
);
	logic [8:0] low_cnt;
	logic [8:0] next_low_cnt;
	logic       q_rd;
	// Saturates so a long hold never wraps back into the glitch range
	always_comb
	begin
		next_low_cnt = low_cnt;
		if (i_rst_pin_b)
			next_low_cnt = 9'h000;
		else if (low_cnt != 9'h1FF)
			next_low_cnt = low_cnt + 9'h001;
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			low_cnt <= 9'h000;
		else
			low_cnt <= next_low_cnt;
	end
	assign q_rd = i_reg_rd && i_reg_addr >= ADDR_QUEUE_LO && i_reg_addr <= ADDR_QUEUE_HI;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	property p_rst_out;
		$rose(i_rst_b) |-> o_reg_rdata == 8'h00 && !o_int_oe;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
	property p_evt_int;
		i_evt_valid && o_evt_ready && i_evt_req.src == KEF_SRC_KEY |=> o_int_oe;
	endproperty
	a_evt_int: assert property (p_evt_int) else $error("key event raised no interrupt");
	property p_int_od;
		o_int_out == 1'b0;
	endproperty
	a_int_od: assert property (p_int_od) else $error("interrupt pin drives high");
	property p_hold;
		q_rd && i_xfer_busy ##1 i_xfer_busy [*2] |-> !o_evt_ready;
	endproperty
	a_hold: assert property (p_hold) else $error("queue update during transfer");
	property p_rdz;
		i_reg_rd && (i_reg_addr == ADDR_RESTART || i_reg_addr > ADDR_SRC_CFG)
			|=> o_reg_rdata == 8'h00;
	endproperty
	a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
	property p_soft;
		i_reg_wr && i_reg_addr == ADDR_RESTART && i_reg_wdata[RESTART_BIT]
			|-> ##[1:4] o_in_reset;
	endproperty
	a_soft: assert property (p_soft) else $error("soft restart ignored");
	property p_pin_glitch;
		$rose(o_in_reset) && !i_rst_pin_b |-> low_cnt >= 9'h0C8;
	endproperty
	a_pin_glitch: assert property (p_pin_glitch) else $error("short pin low reset");
	property p_pin_take;
		low_cnt == 9'h0E6 |-> o_in_reset;
	endproperty
	a_pin_take: assert property (p_pin_take) else $error("pin low gave no reset");
endmodule
bind kef_top kef_top_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_rst_pin_b(i_rst_pin_b), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
	.i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_xfer_busy(i_xfer_busy),
	.o_reg_rdata(o_reg_rdata), .i_evt_valid(i_evt_valid), .i_evt_req(i_evt_req),
	.o_evt_ready(o_evt_ready), .o_int_out(o_int_out), .o_int_oe(o_int_oe),
	.o_in_reset(o_in_reset));

// ---- tb/kef_host_model.sv ----
// Host side register master model
`timescale 1ns/10ps
module kef_host_model
(
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	output logic [7:0]      o_addr,
	output logic            o_rd,
	output logic            o_wr,
	output logic [7:0]      o_wdata,
	output logic            o_busy
);
	logic [7:0] q;
	initial
	begin
		o_addr = 8'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_busy = 1'b0;
	end
	// One byte access; the only configuration path
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge i_clk);
		o_addr <= a;
		o_wr <= w;
		o_rd <= !w;
		o_wdata <= d;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_wr <= 1'b0;
		o_addr <= ~a;
		@(posedge i_clk);
		@(posedge i_clk);
		q = i_rdata;
	end
	endtask
	// Held across a whole burst drain
	task automatic frame(input logic b);
	begin
		@(posedge i_clk);
		o_busy <= b;
	end
	endtask
endmodule

// ---- tb/key_event_fifo_bench.sv ----
// Self-checking bench of the key event block
`timescale 1ns/10ps
module key_event_fifo_bench import kef_pkg::*;;
	logic         i_clk;
	logic         rst_b;
	logic         pin_b;
	logic         ev_v;
	kef_evt_req_t ev_r;
	logic [7:0]   addr, wdata, rdata;
	logic         rd, wr, busy, ev_rdy, int_out, int_oe, in_rst;
	int           failures;
	int           num_checks;
	int           cycles = 0;
	kef_top dut (.i_clk(i_clk), .i_rst_b(rst_b), .i_rst_pin_b(pin_b), .i_reg_addr(addr),
		.i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_xfer_busy(busy),
		.o_reg_rdata(rdata), .i_evt_valid(ev_v), .i_evt_req(ev_r), .o_evt_ready(ev_rdy),
		.o_int_out(int_out), .o_int_oe(int_oe), .o_in_reset(in_rst));
	kef_host_model h (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd),
		.o_wr(wr), .o_wdata(wdata), .o_busy(busy));
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	task automatic close_out;
	begin
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	begin
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
	begin
		h.acc(1'b0, a, 8'h00);
		chk(h.q, exp);
	end
	endtask
	task automatic push(input kef_src_t s, input logic [7:0] e);
	begin
		ev_v <= 1'b1;
		ev_r <= {s, e};
		@(posedge i_clk);
		while (ev_rdy !== 1'b1)
			@(posedge i_clk);
	end
	endtask
	// Idle record is scrambled so stale data is never trusted
	task automatic stop;
	begin
		ev_v <= 1'b0;
		ev_r <= ~ev_r;
		@(posedge i_clk);
	end
	endtask
	task automatic t_fill;
	begin
		for (int i = 0; i < 17; i++)
			push(KEF_SRC_KEY, {i[0], 7'(i)});
		stop();
		rc(ADDR_TALLY, 8'h10);
		rc(ADDR_STATUS, 8'h05);
		chk({7'h00, int_oe}, 8'h01);
		h.acc(1'b1, ADDR_STATUS, 8'h01);
		rc(ADDR_STATUS, 8'h04);
		chk({7'h00, int_oe}, 8'h00);
		// Overrun interrupt enable is otherwise never exercised
		h.acc(1'b1, ADDR_SRC_CFG, 8'h0C);
		chk({7'h00, int_oe}, 8'h01);
	end
	endtask
	task automatic t_drain;
	begin
		h.frame(1'b1);
		for (int i = 0; i < 16; i++)
		begin
			if (i == 1)
			begin
				ev_v <= 1'b1;
				ev_r <= {KEF_SRC_KEY, 8'hD5};
			end
			rc(ADDR_QUEUE_LO + 8'(i), {i[0], 7'(i)});
		end
		chk({7'h00, ev_rdy}, 8'h00);
		h.frame(1'b0);
		push(KEF_SRC_KEY, 8'hD5);
		stop();
		rc(ADDR_TALLY, 8'h01);
		rc(ADDR_QUEUE_HI, 8'hD5);
		rc(ADDR_QUEUE_LO, 8'h00);
		rc(ADDR_TALLY, 8'h00);
	end
	endtask
	task automatic t_src;
	begin
		push(KEF_SRC_GPI, 8'h21);
		push(KEF_SRC_LOGIC, 8'h22);
		stop();
		rc(ADDR_TALLY, 8'h00);
		h.acc(1'b1, ADDR_SRC_CFG, 8'h0B);
		push(KEF_SRC_GPI, 8'hA1);
		push(KEF_SRC_LOGIC, 8'h22);
		stop();
		rc(ADDR_TALLY, 8'h02);
		rc(ADDR_SRC_CFG, 8'h0B);
	end
	endtask
	task automatic t_restart;
	begin
		h.acc(1'b1, ADDR_RESTART, 8'h04);
		rc(ADDR_TALLY, 8'h00);
		rc(ADDR_SRC_CFG, SRC_CFG_RESET);
		rc(ADDR_STATUS, 8'h00);
		chk({7'h00, int_oe}, 8'h00);
	end
	endtask
	task automatic t_pin;
	begin
		push(KEF_SRC_KEY, 8'h01);
		stop();
		pin_b <= 1'b0;
		repeat (50) @(posedge i_clk);
		pin_b <= 1'b1;
		repeat (10) @(posedge i_clk);
		chk({7'h00, in_rst}, 8'h00);
		rc(ADDR_TALLY, 8'h01);
		pin_b <= 1'b0;
		repeat (240) @(posedge i_clk);
		chk({7'h00, in_rst}, 8'h01);
		pin_b <= 1'b1;
		repeat (240) @(posedge i_clk);
		chk({7'h00, in_rst}, 8'h00);
		rc(ADDR_TALLY, 8'h00);
	end
	endtask
	initial
	begin
		rst_b = 1'b0;
		pin_b = 1'b1;
		ev_v = 1'b0;
		ev_r = '0;
		failures = 0;
		num_checks = 0;
		repeat (8) @(posedge i_clk);
		rst_b <= 1'b1;
		rc(ADDR_TALLY, 8'h00);
		rc(ADDR_SRC_CFG, SRC_CFG_RESET);
		rc(8'h7F, 8'h00);
		t_fill();
		t_drain();
		t_src();
		t_restart();
		t_pin();
		close_out();
	end
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			close_out();
		end
	end
endmodule
